/* pti_pkg.sv */
// constants, types and register map of the test/indirect access register block
// Overview of operation
// - writing 1 to program strobe loads selected internal register from write value in test mode only, self-clears
// - test enable bit turns testability/configuration mode on or off; resets to 0
// - 5-bit fetch address selects the internal register copied into the results
// - 5-bit program address selects the internal register that takes the write value
// - low result holds narrow target from bit 0, or low 16 bits of wide target
// - high result is zero for narrow targets, upper bits for wide targets
// - write value register is 16-bit read/write, resets to 0, feeds program transfers
// - fast reset bit shortens software-reset interval from 256 ms to 10 us
// - heartbeat disable bit suppresses the signal quality test pulse; resets to 0
// - pll lock bit holds 10M receive pll on reference and blocks 10M receive
// - read-only polarity bit reads 0 normal, 1 reversed 10Base-T receive polarity
// - read-only 4-bit arbiter state field reads 1011 after reset
// - device answers only management frames carrying its configured 5-bit address
package pti_pkg;
  localparam logic [4:0] REG_ACCESS_CTL   = 5'h14;
  localparam logic [4:0] REG_RESULT_LOW   = 5'h15;
  localparam logic [4:0] REG_RESULT_HIGH  = 5'h16;
  localparam logic [4:0] REG_WRITE_VALUE  = 5'h17;
  localparam logic [4:0] REG_SPECIAL_CS   = 5'h1B;
  localparam logic [4:0] REG_TEST_RSVD    = 5'h1C;

  localparam int CTL_FETCH_BIT  = 15;
  localparam int CTL_PROG_BIT   = 14;
  localparam int CTL_TEST_BIT   = 10;
  localparam int CTL_FADDR_LSB  = 5;
  localparam int CTL_PADDR_LSB  = 0;
  localparam int SCS_FAST_BIT   = 12;
  localparam int SCS_HB_BIT     = 11;
  localparam int SCS_PLL_BIT    = 10;
  localparam int SCS_POL_BIT    = 4;
  localparam int SCS_ARB_LSB    = 0;

  localparam logic [3:0]  ARB_STATE_RST = 4'hB;
  localparam logic [15:0] WORD_RST      = 16'h0000;
  // internal targets 0x10..0x1F are 32 bits wide, the rest 16 bits
  localparam logic [31:0] TCR_WIDE_MAP  = 32'hFFFF_0000;

  localparam logic [4:0] PRE_LAST  = 5'h1F;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_WRITE  = 2'h1;

  localparam int MCLK_MHZ        = 200;
  localparam int SR_SLOW_MS      = 256;
  localparam int SR_FAST_US      = 10;
  localparam int SR_SLOW_CYC     = SR_SLOW_MS * 1000 * MCLK_MHZ;
  localparam int SR_FAST_CYC     = SR_FAST_US * MCLK_MHZ;
  localparam int SR_TMR_W        = 26;

  typedef enum logic [2:0] {
    MD_PRE, MD_ST, MD_OP, MD_ADDR, MD_TA, MD_DATA
  } pti_mdio_e;

  typedef struct packed {
    logic        en;
    logic [4:0]  addr;
    logic [15:0] data;
  } pti_wr_s;
endpackage

/* pti_regs.sv */
// management-interface register block: indirect test access and special control/status
`timescale 1ns/10ps
module pti_regs #(
  parameter int SLOW_CYC = pti_pkg::SR_SLOW_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       mdc,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe_n,
  input  wire logic [4:0] device_bus_address,
  input  wire logic       polarity_reversed_in,
  input  wire logic [3:0] arbiter_state_in,
  input  wire logic       sqe_test_req,
  input  wire logic       soft_reset_start,
  output logic            test_mode,
  output logic            heartbeat_disable,
  output logic            pll_reference_lock,
  output logic            rx10_enable,
  output logic            sqe_test_pulse,
  output logic            soft_reset_busy
);
  function automatic logic is_wide(input logic [4:0] a);
    return pti_pkg::TCR_WIDE_MAP[a];
  endfunction

  // ---------------- serial management frame engine ----------------
  pti_pkg::pti_mdio_e st_q, st_d;
  logic [4:0]         cnt_q, cnt_d;
  logic [15:0]        sh_q, sh_d;
  logic [4:0]         regad_q, regad_d;
  logic               rd_op_q, rd_op_d;
  logic               match_q, match_d;
  logic               mo_q, mo_d;
  logic               oe_n_q, oe_n_d;
  logic               mdc_q;
  logic [4:0]         dev_addr_q;
  pti_pkg::pti_wr_s   wr_q, wr_d;
  logic [15:0]        rd_word;
  logic               mdc_rise;
  logic [1:0]         op_bits;

  assign mdc_rise = mdc & ~mdc_q;
  assign op_bits  = {sh_q[0], mdio_i};

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    regad_d = regad_q;
    rd_op_d = rd_op_q;
    match_d = match_q;
    mo_d    = mo_q;
    oe_n_d  = oe_n_q;
    wr_d    = '0;
    if (mdc_rise) begin
      unique case (st_q)
        pti_pkg::MD_PRE: begin
          if (mdio_i) begin
            cnt_d = (cnt_q == pti_pkg::PRE_LAST) ? cnt_q : cnt_q + 5'h01;
          end else begin
            // a zero after at least 31 ones is the first start bit
            if (cnt_q == pti_pkg::PRE_LAST) st_d = pti_pkg::MD_ST;
            cnt_d = '0;
          end
        end
        pti_pkg::MD_ST: begin
          st_d = mdio_i ? pti_pkg::MD_OP : pti_pkg::MD_PRE;
        end
        pti_pkg::MD_OP: begin
          sh_d  = {sh_q[14:0], mdio_i};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'h01) begin
            cnt_d   = '0;
            rd_op_d = (op_bits == pti_pkg::OP_READ);
            st_d    = (op_bits == pti_pkg::OP_READ || op_bits == pti_pkg::OP_WRITE) ?
                      pti_pkg::MD_ADDR : pti_pkg::MD_PRE;
          end
        end
        pti_pkg::MD_ADDR: begin
          sh_d  = {sh_q[14:0], mdio_i};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'h09) begin
            cnt_d   = '0;
            match_d = (sh_q[8:4] == dev_addr_q);
            regad_d = {sh_q[3:0], mdio_i};
            st_d    = pti_pkg::MD_TA;
          end
        end
        pti_pkg::MD_TA: begin
          if (cnt_q == 5'h00) begin
            cnt_d = 5'h01;
            if (rd_op_q && match_q) begin
              oe_n_d = 1'b0;
              mo_d   = 1'b0;
              sh_d   = rd_word;
            end
          end else begin
            cnt_d = '0;
            st_d  = pti_pkg::MD_DATA;
            mo_d  = sh_q[15];
            sh_d  = {sh_q[14:0], 1'b0};
          end
        end
        pti_pkg::MD_DATA: begin
          cnt_d = cnt_q + 5'h01;
          if (rd_op_q) begin
            mo_d = sh_q[15];
            sh_d = {sh_q[14:0], 1'b0};
          end else begin
            sh_d = {sh_q[14:0], mdio_i};
          end
          if (cnt_q == 5'h0F) begin
            st_d   = pti_pkg::MD_PRE;
            cnt_d  = '0;
            oe_n_d = 1'b1;
            mo_d   = 1'b0;
            if (!rd_op_q && match_q) begin
              wr_d.en   = 1'b1;
              wr_d.addr = regad_q;
              wr_d.data = {sh_q[14:0], mdio_i};
            end
          end
        end
        default: st_d = pti_pkg::MD_PRE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    mdc_q <= mdc;
    if (rst) begin
      st_q       <= pti_pkg::MD_PRE;
      cnt_q      <= '0;
      sh_q       <= '0;
      regad_q    <= '0;
      rd_op_q    <= 1'b0;
      match_q    <= 1'b0;
      mo_q       <= 1'b0;
      oe_n_q     <= 1'b1;
      wr_q       <= '0;
      // address strap is caught while reset is held
      dev_addr_q <= device_bus_address;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      regad_q <= regad_d;
      rd_op_q <= rd_op_d;
      match_q <= match_d;
      mo_q    <= mo_d;
      oe_n_q  <= oe_n_d;
      wr_q    <= wr_d;
    end
  end

  assign mdio_o    = mo_q;
  assign mdio_oe_n = oe_n_q;

  // ---------------- register file ----------------
  logic        fetch_q, fetch_d, prog_q, prog_d, tmode_q, tmode_d;
  logic [4:0]  faddr_q, faddr_d, paddr_q, paddr_d;
  logic [15:0] res_lo_q, res_lo_d, res_hi_q, res_hi_d, wval_q, wval_d;
  logic [31:0] tcr_q [32];
  logic [31:0] tcr_d [32];
  logic        fast_q, fast_d, hb_q, hb_d, pll_q, pll_d, rx10_q, rx10_d;
  logic        pol_q, pol_d, sqe_q, sqe_d;
  logic [3:0]  arb_q, arb_d;
  logic [31:0] fetch_word;

  assign fetch_word = tcr_q[faddr_q];

  always_comb begin
    rd_word = '0;
    unique case (regad_q)
      pti_pkg::REG_ACCESS_CTL: begin
        rd_word[pti_pkg::CTL_FETCH_BIT] = fetch_q;
        rd_word[pti_pkg::CTL_PROG_BIT]  = prog_q;
        rd_word[pti_pkg::CTL_TEST_BIT]  = tmode_q;
        rd_word[pti_pkg::CTL_FADDR_LSB +: 5] = faddr_q;
        rd_word[pti_pkg::CTL_PADDR_LSB +: 5] = paddr_q;
      end
      pti_pkg::REG_RESULT_LOW:  rd_word = res_lo_q;
      pti_pkg::REG_RESULT_HIGH: rd_word = res_hi_q;
      pti_pkg::REG_WRITE_VALUE: rd_word = wval_q;
      pti_pkg::REG_SPECIAL_CS: begin
        rd_word[pti_pkg::SCS_FAST_BIT] = fast_q;
        rd_word[pti_pkg::SCS_HB_BIT]   = hb_q;
        rd_word[pti_pkg::SCS_PLL_BIT]  = pll_q;
        rd_word[pti_pkg::SCS_POL_BIT]  = pol_q;
        rd_word[pti_pkg::SCS_ARB_LSB +: 4] = arb_q;
      end
      default: rd_word = '0; // reserved test register and unmapped reads give zero
    endcase
  end

  always_comb begin
    fetch_d  = fetch_q;
    prog_d   = prog_q;
    tmode_d  = tmode_q;
    faddr_d  = faddr_q;
    paddr_d  = paddr_q;
    res_lo_d = res_lo_q;
    res_hi_d = res_hi_q;
    wval_d   = wval_q;
    tcr_d    = tcr_q;
    fast_d   = fast_q;
    hb_d     = hb_q;
    pll_d    = pll_q;
    // transfers only act in test mode; the strobe clears either way
    if (fetch_q) begin
      fetch_d = 1'b0;
      if (tmode_q) begin
        res_lo_d = fetch_word[15:0];
        res_hi_d = is_wide(faddr_q) ? fetch_word[31:16] : pti_pkg::WORD_RST;
      end
    end
    if (prog_q) begin
      prog_d = 1'b0;
      if (tmode_q) begin
        // wide targets take two programs: the earlier low half moves up
        tcr_d[paddr_q] = is_wide(paddr_q) ? {tcr_q[paddr_q][15:0], wval_q} :
                         {pti_pkg::WORD_RST, wval_q};
      end
    end
    if (wr_q.en) begin
      unique case (wr_q.addr)
        pti_pkg::REG_ACCESS_CTL: begin
          // a new strobe in the cycle of its self-clear wins
          if (wr_q.data[pti_pkg::CTL_FETCH_BIT]) fetch_d = 1'b1;
          if (wr_q.data[pti_pkg::CTL_PROG_BIT]) prog_d = 1'b1;
          tmode_d = wr_q.data[pti_pkg::CTL_TEST_BIT];
          faddr_d = wr_q.data[pti_pkg::CTL_FADDR_LSB +: 5];
          paddr_d = wr_q.data[pti_pkg::CTL_PADDR_LSB +: 5];
        end
        pti_pkg::REG_WRITE_VALUE: wval_d = wr_q.data;
        pti_pkg::REG_SPECIAL_CS: begin
          fast_d = wr_q.data[pti_pkg::SCS_FAST_BIT];
          hb_d   = wr_q.data[pti_pkg::SCS_HB_BIT];
          pll_d  = wr_q.data[pti_pkg::SCS_PLL_BIT];
        end
        default: ;
      endcase
    end
    rx10_d = ~pll_d;
    sqe_d  = sqe_test_req & ~hb_q;
    pol_d  = polarity_reversed_in;
    arb_d  = arbiter_state_in;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fetch_q  <= 1'b0;
      prog_q   <= 1'b0;
      tmode_q  <= 1'b0;
      faddr_q  <= '0;
      paddr_q  <= '0;
      res_lo_q <= pti_pkg::WORD_RST;
      res_hi_q <= pti_pkg::WORD_RST;
      wval_q   <= pti_pkg::WORD_RST;
      for (int i = 0; i < 32; i++) tcr_q[i] <= '0;
      fast_q   <= 1'b0;
      hb_q     <= 1'b0;
      pll_q    <= 1'b0;
      rx10_q   <= 1'b1;
      sqe_q    <= 1'b0;
      pol_q    <= 1'b0;
      arb_q    <= pti_pkg::ARB_STATE_RST;
    end else begin
      fetch_q  <= fetch_d;
      prog_q   <= prog_d;
      tmode_q  <= tmode_d;
      faddr_q  <= faddr_d;
      paddr_q  <= paddr_d;
      res_lo_q <= res_lo_d;
      res_hi_q <= res_hi_d;
      wval_q   <= wval_d;
      tcr_q    <= tcr_d;
      fast_q   <= fast_d;
      hb_q     <= hb_d;
      pll_q    <= pll_d;
      rx10_q   <= rx10_d;
      sqe_q    <= sqe_d;
      pol_q    <= pol_d;
      arb_q    <= arb_d;
    end
  end

  // ---------------- software-reset interval timer ----------------
  logic                         busy_q, busy_d;
  logic [pti_pkg::SR_TMR_W-1:0] tmr_q, tmr_d;

  always_comb begin
    busy_d = busy_q;
    tmr_d  = tmr_q;
    if (busy_q) begin
      if (tmr_q == '0) busy_d = 1'b0;
      else tmr_d = tmr_q - 26'h0000001;
    end else if (soft_reset_start) begin
      busy_d = 1'b1;
      tmr_d  = fast_q ? 26'(pti_pkg::SR_FAST_CYC - 1) : 26'(SLOW_CYC - 1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_q <= 1'b0;
      tmr_q  <= '0;
    end else begin
      busy_q <= busy_d;
      tmr_q  <= tmr_d;
    end
  end

  assign test_mode          = tmode_q;
  assign heartbeat_disable  = hb_q;
  assign pll_reference_lock = pll_q;
  assign rx10_enable        = rx10_q;
  assign sqe_test_pulse     = sqe_q;
  assign soft_reset_busy    = busy_q;

  // ---------------- checks ----------------
  localparam logic [25:0] FAST_LOAD_A = 26'(pti_pkg::SR_FAST_CYC - 1);

  fetch_clear_a: assert property (@(posedge mclk) disable iff (rst)
    fetch_q && !(wr_q.en && wr_q.addr == pti_pkg::REG_ACCESS_CTL) |=> !fetch_q)
    else $error("fetch strobe did not self-clear");
  prog_load_a: assert property (@(posedge mclk) disable iff (rst)
    prog_q && tmode_q && !is_wide(paddr_q) |=>
    tcr_q[$past(paddr_q)] == {16'h0000, $past(wval_q)})
    else $error("program did not load write value");
  fetch_low_a: assert property (@(posedge mclk) disable iff (rst)
    fetch_q && tmode_q |=> res_lo_q == $past(fetch_word[15:0]))
    else $error("low result mismatch");
  fetch_high_a: assert property (@(posedge mclk) disable iff (rst)
    fetch_q && tmode_q |=> res_hi_q == ($past(is_wide(faddr_q)) ? $past(fetch_word[31:16]) : 16'h0000))
    else $error("high result mismatch");
  reset_values_a: assert property (@(posedge mclk)
    $fell(rst) |-> arb_q == 4'hB && !tmode_q && wval_q == 16'h0000 && !hb_q)
    else $error("wrong value after reset");
  heartbeat_gate_a: assert property (@(posedge mclk) disable iff (rst)
    hb_q && sqe_test_req |=> !sqe_q)
    else $error("heartbeat pulse not suppressed");
  pll_block_a: assert property (@(posedge mclk) disable iff (rst)
    pll_q |-> !rx10_q)
    else $error("10M receive enabled while pll held on reference");
  fast_timer_a: assert property (@(posedge mclk) disable iff (rst)
    !busy_q && soft_reset_start && fast_q |=> busy_q ##0 tmr_q == FAST_LOAD_A)
    else $error("fast reset interval not loaded");
  addr_match_a: assert property (@(posedge mclk) disable iff (rst)
    !oe_n_q |-> match_q && rd_op_q)
    else $error("drove data line without address match");
endmodule

/* pti_station.sv */
// management station model driving the serial management interface
`timescale 1ns/10ps
module pti_station (
  input  wire logic mclk,
  input  wire logic mdio_o,
  input  wire logic mdio_oe_n,
  output logic      mdc,
  output logic      mdio_i
);
  logic st_en;
  logic st_bit;

  // the line is pulled up, so a released line reads 1 instead of a stale value
  assign mdio_i = !mdio_oe_n ? mdio_o : (st_en ? st_bit : 1'b1);

  initial begin
    mdc = 1'b0;
    st_en = 1'b0;
    st_bit = 1'b1;
  end

  // one mdc period is 8 mclk; mdc rests low between frames
  task automatic cyc(input logic b, input logic en, output logic s);
    st_en = en;
    st_bit = b;
    repeat (4) @(negedge mclk);
    s = mdio_i;
    mdc = 1'b1;
    repeat (4) @(negedge mclk);
    mdc = 1'b0;
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic        s;
    logic        wr;
    logic [13:0] hdr;
    wr = (op == pti_pkg::OP_WRITE);
    hdr = {2'b01, op, phy, ra};
    @(negedge mclk);
    for (int i = 0; i < 32; i++) cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) cyc(hdr[i], 1'b1, s);
    // reads release the line for the whole turnaround
    cyc(1'b1, wr, s);
    cyc(1'b0, wr, s);
    for (int i = 15; i >= 0; i--) begin
      cyc(wd[i], wr, s);
      rd[i] = s;
    end
    st_en = 1'b0;
    repeat (8) @(negedge mclk);
  endtask
endmodule

/* tb.sv */
// self-checking testbench of the indirect test access register block
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic        wr;
    logic [4:0]  ra;
    logic [15:0] wd;
    logic [15:0] exp;
  } pti_row_s;

  localparam logic [4:0] PHY  = 5'h0A;
  localparam int         SLOW = 50;

  logic        mclk;
  logic        rst;
  logic        mdc;
  logic        mdio_i;
  logic        mdio_o;
  logic        mdio_oe_n;
  logic [4:0]  strap;
  logic        pol_in;
  logic [3:0]  arb_in;
  logic        sqe_req;
  logic        sr_start;
  logic        test_mode;
  logic        hb_dis;
  logic        pll_lock;
  logic        rx10_en;
  logic        sqe_pulse;
  logic        sr_busy;
  logic [15:0] rd;
  int          mismatches;
  int          checked;
  int          n;
  pti_row_s    rows [12];

  always #2.5 mclk = ~mclk;

  pti_regs #(.SLOW_CYC(SLOW)) dut (
    .mclk(mclk), .rst(rst), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
    .mdio_oe_n(mdio_oe_n), .device_bus_address(strap), .polarity_reversed_in(pol_in),
    .arbiter_state_in(arb_in), .sqe_test_req(sqe_req), .soft_reset_start(sr_start),
    .test_mode(test_mode), .heartbeat_disable(hb_dis), .pll_reference_lock(pll_lock),
    .rx10_enable(rx10_en), .sqe_test_pulse(sqe_pulse), .soft_reset_busy(sr_busy)
  );

  pti_station sta (
    .mclk(mclk), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .mdc(mdc), .mdio_i(mdio_i)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    sta.frame(pti_pkg::OP_WRITE, PHY, ra, wd, rd);
  endtask

  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    sta.frame(pti_pkg::OP_READ, PHY, ra, 16'h0000, rd);
    chk(rd, exp);
  endtask

  // counts busy cycles over a window longer than the longest interval
  task automatic count_busy();
    @(negedge mclk);
    sr_start = 1'b1;
    n = 0;
    // busy is already up at the edge that drops the start pulse, so that one counts too
    repeat (2101) begin
      @(negedge mclk);
      sr_start = 1'b0;
      if (sr_busy === 1'b1) n++;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    strap = PHY;
    pol_in = 1'b0;
    arb_in = 4'hB;
    sqe_req = 1'b0;
    sr_start = 1'b0;
    mismatches = 0;
    checked = 0;
    // software keeps reserved bits zero and never writes the reserved register
    rows = '{'{1'b0, 5'h14, 16'h0000, 16'h0000}, '{1'b0, 5'h15, 16'h0000, 16'h0000},
             '{1'b0, 5'h16, 16'h0000, 16'h0000}, '{1'b0, 5'h17, 16'h0000, 16'h0000},
             '{1'b0, 5'h1B, 16'h0000, 16'h000B}, '{1'b1, 5'h17, 16'hA5C3, 16'hA5C3},
             '{1'b1, 5'h14, 16'h03FF, 16'h03FF}, '{1'b1, 5'h14, 16'h0400, 16'h0400},
             '{1'b1, 5'h15, 16'hFFFF, 16'h0000}, '{1'b1, 5'h16, 16'hFFFF, 16'h0000},
             '{1'b1, 5'h1B, 16'h1C00, 16'h1C0B}, '{1'b1, 5'h05, 16'hFFFF, 16'h0000}};
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    chk({13'h0, hb_dis, pll_lock, rx10_en}, 16'h0001);
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].ra, rows[i].wd);
      rd_chk(rows[i].ra, rows[i].exp);
    end
    $display("test register table done");
    // wide target takes the high half first
    wr(5'h17, 16'h1234);
    wr(5'h14, 16'h4412);
    wr(5'h17, 16'h5678);
    wr(5'h14, 16'h4412);
    wr(5'h14, 16'h8640);
    rd_chk(5'h15, 16'h5678);
    rd_chk(5'h16, 16'h1234);
    rd_chk(5'h14, 16'h0640);
    chk({15'h0, test_mode}, 16'h0001);
    $display("test wide target done");
    wr(5'h17, 16'hBEEF);
    wr(5'h14, 16'h4403);
    wr(5'h14, 16'h8460);
    rd_chk(5'h15, 16'hBEEF);
    rd_chk(5'h16, 16'h0000);
    wr(5'h17, 16'h1111);
    wr(5'h14, 16'h4003);
    chk({15'h0, test_mode}, 16'h0000);
    wr(5'h14, 16'h8460);
    rd_chk(5'h15, 16'hBEEF);
    $display("test narrow target done");
    sta.frame(pti_pkg::OP_READ, 5'h0B, 5'h17, 16'h0000, rd);
    chk(rd, 16'hFFFF);
    sta.frame(pti_pkg::OP_WRITE, 5'h0B, 5'h17, 16'h2222, rd);
    rd_chk(5'h17, 16'h1111);
    $display("test foreign address done");
    wr(5'h1B, 16'h0C00);
    chk({13'h0, hb_dis, pll_lock, rx10_en}, 16'h0006);
    sqe_req = 1'b1;
    repeat (3) @(negedge mclk);
    chk({15'h0, sqe_pulse}, 16'h0000);
    wr(5'h1B, 16'h0000);
    chk({15'h0, sqe_pulse}, 16'h0001);
    sqe_req = 1'b0;
    pol_in = 1'b1;
    arb_in = 4'h5;
    rd_chk(5'h1B, 16'h0015);
    $display("test control status done");
    count_busy();
    chk(16'(n), 16'h0032);
    wr(5'h1B, 16'h1000);
    count_busy();
    chk(16'(n), 16'h07D0);
    $display("test soft reset interval done");
    @(negedge mclk);
    rst = 1'b1;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    chk({12'h0, test_mode, hb_dis, pll_lock, rx10_en}, 16'h0001);
    rd_chk(5'h17, 16'h0000);
    rd_chk(5'h14, 16'h0000);
    $display("test second reset done");
    end_of_test();
  end
endmodule
